// File: src/rv_pkg.sv
/*
  Shared constants for the reset, vector and low-voltage control block:
  vector numbering, register offsets, field positions and reset values.
  Assumes an 8-bit register port and a 32-entry vector table that ends
  at the top of the 16-bit address space.
*/
package rv_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Vector table.
  localparam int unsigned VEC_COUNT = 32;       // Entries in the table.
  localparam int unsigned VEC_W     = 5;        // Bits of a vector number.
  // Location of the reset vector high byte; each vector takes two bytes.
  localparam logic [15:0] VEC_TOP_ADDR = 16'hFFFE;
  localparam logic [4:0]  VEC_RESET    = 5'h00; // Shared reset vector.
  localparam logic [4:0]  VEC_SWI      = 5'h01; // Software interrupt.
  localparam logic [4:0]  VEC_LVW      = 5'h03; // Low-voltage warning.
  // Slots that carry a source; all other slots stay inactive.
  localparam logic [31:0] VEC_ASSIGNED = 32'h47B7_F86B;
  // Slots served by this block's own logic, not by the peripheral inputs.
  localparam logic [31:0] VEC_INTERNAL = 32'h0000_000B;

  ////////////////////////////////////////////////////////////////////////
  // Register offsets; the interrupt status register is the direct-page one.
  localparam logic [7:0] REG_IRQ_STATUS   = 8'h00;
  localparam logic [7:0] REG_RESET_STATUS = 8'h01;
  localparam logic [7:0] REG_DEBUG_FORCE  = 8'h02;
  localparam logic [7:0] REG_SYS_OPT_ONE  = 8'h03;
  localparam logic [7:0] REG_IRQ_MASK     = 8'h04;
  localparam logic [7:0] REG_DEVICE_ID    = 8'h05;
  localparam logic [7:0] REG_PMC_ONE      = 8'h06;
  localparam logic [7:0] REG_PMC_TWO      = 8'h07;
  localparam logic [7:0] REG_VECTOR       = 8'h08;

  // Arbitrary identification value, not tied to any part.
  localparam logic [7:0] DEVICE_ID_VAL = 8'h5A;

  ////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int unsigned PMC1_WARN_FLAG = 7;   // Warning flag, read only.
  localparam int unsigned PMC1_WARN_ACK  = 6;   // Write one to clear flag.
  localparam int unsigned PMC1_WARN_IE   = 5;   // Warning interrupt enable.
  localparam int unsigned PMC1_RESET_EN  = 4;   // Low-voltage reset enable.
  localparam int unsigned PMC1_STOP_EN   = 3;   // Detection kept in stop.
  localparam int unsigned PMC1_DETECT_EN = 2;   // Detection enable.
  localparam int unsigned PMC2_THRESH    = 5;   // Threshold select.
  localparam int unsigned PMC2_STOP2     = 0;   // Deepest stop requested.
  localparam int unsigned RS_POR         = 7;
  localparam int unsigned RS_PIN         = 6;
  localparam int unsigned RS_WDOG        = 5;
  localparam int unsigned RS_ILOP        = 4;
  localparam int unsigned RS_ILAD        = 3;
  localparam int unsigned RS_LOWV        = 1;
  localparam int unsigned SYSTEM_OPTIONS_ONE_WDOG_EN  = 7;
  localparam int unsigned EV_WARN        = 0;   // Warning seen.
  localparam int unsigned EV_LOWV_TRIP   = 1;   // Low-voltage reset taken.
  localparam int unsigned EV_STOP2_DENY  = 2;   // Deepest stop refused.
  localparam int unsigned EV_W           = 3;   // Event bits.

  ////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic       DETECT_EN_RST = 1'b1;
  localparam logic       RESET_EN_RST  = 1'b1;
  localparam logic       WDOG_EN_RST   = 1'b1;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;

  // Stop depth presented to the power controller.
  typedef enum logic [1:0] {
    STOP_NONE = 2'b00,
    STOP_3    = 2'b01,
    STOP_2    = 2'b10
  } stop_e;

  // Reset sequencer states.
  typedef enum logic [1:0] {
    RST_POR_HOLD = 2'b00,
    RST_RUN      = 2'b01,
    RST_HOLD     = 2'b10
  } rst_state_e;

endpackage : rv_pkg

// File: src/vec_if.sv
/*
  Carrier between the controller and its priority encoder: the pending
  request vector out, the winning vector number and a valid flag back.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface vec_if;
  logic [31:0] pending;   // One bit per vector slot.
  logic [4:0]  num;       // Winning vector number.
  logic        valid;     // Any slot pending.
  modport enc (input pending, output num, output valid);
  modport ctl (output pending, input num, input valid);
endinterface : vec_if
`default_nettype wire

// File: src/sync_bank.sv
/*
  Two-stage synchroniser bank for inputs that come from outside the
  clock domain. Assumes a synchronous active-low reset and a clock
  enable that freezes the stages.
*/
`timescale 1ns/100ps
`default_nettype none
module sync_bank #(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);

  // Both stages in one state word; the first is read only by the second.
  typedef struct packed {
    logic [W-1:0] first;
    logic [W-1:0] second;
  } sync_s;

  sync_s s;
  sync_s next_s;

  // Shift one stage per enabled edge.
  always_comb begin
    next_s.first  = async_in;
    next_s.second = s.first;
  end

  // Reset clears both stages, which the user sees as all inputs low.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s <= '0;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  assign sync_out = s.second;

endmodule : sync_bank
`default_nettype wire

// File: src/vec_prio_enc.sv
/*
  Fixed priority encoder over the vector slots: the lowest number wins.
  Purely combinational; the caller registers the answer.
*/
`timescale 1ns/100ps
`default_nettype none
module vec_prio_enc
  import rv_pkg::*;
(
  vec_if.enc vp
);

  logic [VEC_COUNT:0]   lower_any;   // Some lower-numbered slot pending.
  logic [VEC_COUNT-1:0] win;         // One-hot winner.

  assign lower_any[0] = 1'b0;

  // Each slot wins only when no lower-numbered slot is pending.
  for (genvar i = 0; i < VEC_COUNT; i++) begin : g_slot
    assign win[i]          = vp.pending[i] & ~lower_any[i];
    assign lower_any[i+1]  = lower_any[i] | vp.pending[i];
  end

  // Turn the one-hot winner into its number.
  always_comb begin
    vp.num = '0;
    for (int unsigned k = 0; k < VEC_COUNT; k++) begin
      if (win[k]) begin
        vp.num = vp.num | k[VEC_W-1:0];
      end
    end
  end

  assign vp.valid = lower_any[VEC_COUNT];

endmodule : vec_prio_enc
`default_nettype wire

// File: src/reset_vector_and_lvd_ctrl.sv
/*
  Reset sequencer, vector priority logic and low-voltage control of a
  small microcontroller. Holds the power-management, reset-status,
  option and event registers, picks the vector the core should fetch
  and drives system reset.
  Assumes: the analog comparators and the reset pin arrive from outside
  the clock domain; watchdog, illegal-access pulses, software interrupt,
  stop request and the peripheral flags come from logic on ref_clk.
*/
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/100ps
`default_nettype none
module reset_vector_and_lvd_ctrl
  import rv_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [7:0]  reg_rdata,
  input  wire logic        lowv_supply_ok,
  input  wire logic        lowv_warn_level,
  input  wire logic        reset_pin_n,
  input  wire logic        watchdog_timeout,
  input  wire logic        illegal_opcode,
  input  wire logic        illegal_address,
  input  wire logic        swi_req,
  input  wire logic        stop_req,
  input  wire logic [31:0] periph_flag,
  input  wire logic [31:0] periph_enable,
  output var  logic        sys_reset,
  output var  logic        cpu_irq_req,
  output var  logic [4:0]  vec_num,
  output var  logic [15:0] vec_addr_hi,
  output var  logic        lowv_active,
  output var  logic        lowv_threshold_select,
  output var  logic [1:0]  stop_mode,
  output var  logic        irq
);

  //////////////////////////////////////////////////////////////////////////
  // State.

  // Every flip-flop of the block outside the synchroniser lives in this one word.
  typedef struct packed {
    rst_state_e      rst_state;                // Reset sequencer.
    logic            sys_reset;                // System reset to core.
    logic [7:0]      reset_status_reg;         // Cause of last reset.
    logic            lowv_warning_flag;        // Sticky warning flag.
    logic            lowv_warning_irq_enable;  // Warning interrupt enable.
    logic            lowv_reset_enable;        // Trip causes reset.
    logic            lowv_stop_enable;         // Detection kept in stop.
    logic            lowv_detect_enable;       // Detection enable.
    logic            lowv_threshold_select;    // Threshold choice.
    logic            stop2_select;             // Deepest stop wanted.
    logic            watchdog_reset_enable;    // Watchdog may reset.
    logic            sopt_written;             // Option write used up.
    logic [EV_W-1:0] irq_status;               // Sticky events.
    logic [EV_W-1:0] irq_mask;                 // Event enables.
    logic [7:0]      rdata;                    // Read answer.
    logic [4:0]      vec_num;                  // Selected vector.
    logic [15:0]     vec_addr_hi;              // Its high byte location.
    logic            cpu_irq;                  // Request to core.
    logic            lowv_active;              // Comparator powered.
    stop_e           stop_mode;                // Present stop depth.
    logic            irq;                      // Event interrupt line.
  } ctrl_s;

  ctrl_s s;
  ctrl_s next_s;

  logic [2:0]  sync_q;         // Synchronised analog and pin inputs.
  logic        supply_ok;      // Supply above selected threshold.
  logic        warn_level;     // Supply near the threshold.
  logic        pin_active;     // External reset pin held low.
  logic        lowv_low;       // Detected low-voltage condition.
  logic        cause_wdog;     // Gated watchdog cause.
  logic        cause_lowv;     // Gated low-voltage cause.
  logic        any_cause;      // Any reset cause this cycle.
  logic        hold_cause;     // Level causes that keep reset asserted.
  logic        both_en;        // Detection kept alive through stop.
  logic        wr_ok;          // Register write accepted.
  logic        warn_set;       // Warning event this cycle.
  logic        deny_set;       // Deepest stop refused this cycle.
  logic [7:0]  pmc_one_rd;     // Read view of control register one.
  logic [7:0]  pmc_two_rd;     // Read view of control register two.
  logic [7:0]  sopt_rd;        // Read view of the option register.

  vec_if vp ();

  //////////////////////////////////////////////////////////////////////////
  // Sub-blocks.

  // Comparators and the reset pin cross into the clock domain here.
  sync_bank #(
    .W        (3)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .async_in ({reset_pin_n, lowv_warn_level, lowv_supply_ok}),
    .sync_out (sync_q)
  );

  // Lowest pending number wins.
  vec_prio_enc u_enc (
    .vp (vp)
  );

  //////////////////////////////////////////////////////////////////////////
  // Input decode.

  // A synchronised pin reads low straight after reset, which simply
  // looks like an asserted pin until the real level has arrived; the
  // power-on hold covers that window anyway.
  assign supply_ok  = sync_q[0];
  assign warn_level = sync_q[1];
  assign pin_active = ~sync_q[2];

  // Comparator outputs count only while detection is powered.
  assign lowv_low   = s.lowv_active & ~supply_ok;
  assign cause_wdog = watchdog_timeout & s.watchdog_reset_enable;
  assign cause_lowv = lowv_low & s.lowv_reset_enable;
  // Pin, illegal opcode and illegal address are never gated.
  assign any_cause  = cause_wdog | cause_lowv | pin_active
                      | illegal_opcode | illegal_address;
  assign hold_cause = cause_lowv | pin_active;
  assign both_en    = s.lowv_detect_enable & s.lowv_stop_enable;
  assign wr_ok      = reg_wr & (s.rst_state == RST_RUN);
  // The warning counts only when its interrupt is enabled.
  assign warn_set   = s.lowv_active & warn_level & s.lowv_warning_irq_enable;
  assign deny_set   = stop_req & (s.stop_mode == STOP_NONE)
                      & s.stop2_select & both_en;

  // Register read views; unused bits read zero.
  always_comb begin
    pmc_one_rd = BYTE_ZERO;
    pmc_one_rd[PMC1_WARN_FLAG] = s.lowv_warning_flag;
    pmc_one_rd[PMC1_WARN_IE]   = s.lowv_warning_irq_enable;
    pmc_one_rd[PMC1_RESET_EN]  = s.lowv_reset_enable;
    pmc_one_rd[PMC1_STOP_EN]   = s.lowv_stop_enable;
    pmc_one_rd[PMC1_DETECT_EN] = s.lowv_detect_enable;
    pmc_two_rd = BYTE_ZERO;
    pmc_two_rd[PMC2_THRESH]    = s.lowv_threshold_select;
    pmc_two_rd[PMC2_STOP2]     = s.stop2_select;
    sopt_rd = BYTE_ZERO;
    sopt_rd[SYSTEM_OPTIONS_ONE_WDOG_EN]     = s.watchdog_reset_enable;
  end

  //////////////////////////////////////////////////////////////////////////
  // Pending vector set.

  // Peripheral slots pass only with their local enable; unassigned slots
  // are masked away for good.
  always_comb begin
    vp.pending = periph_flag & periph_enable & VEC_ASSIGNED & ~VEC_INTERNAL;
    // The reset vector is pending throughout any reset.
    vp.pending[VEC_RESET] = (s.rst_state != RST_RUN);
    vp.pending[VEC_SWI]   = swi_req;
    // The warning flag requests its vector only while enabled.
    vp.pending[VEC_LVW]   = s.lowv_warning_flag & s.lowv_warning_irq_enable;
  end

  //////////////////////////////////////////////////////////////////////////
  // Next-state logic.

  // All register, sequencer and output updates for one enabled edge.
  always_comb begin
    next_s = s;

    // Registers: writes first, so that hardware sets below win.
    if (wr_ok) begin
      case (reg_addr)
        REG_IRQ_STATUS: begin
          // Write one to clear.
          next_s.irq_status = s.irq_status & ~reg_wdata[EV_W-1:0];
        end
        REG_IRQ_MASK: begin
          next_s.irq_mask = reg_wdata[EV_W-1:0];
        end
        REG_SYS_OPT_ONE: begin
          // Only the first write after reset is honoured.
          if (!s.sopt_written) begin
            next_s.watchdog_reset_enable = reg_wdata[SYSTEM_OPTIONS_ONE_WDOG_EN];
            next_s.sopt_written          = 1'b1;
          end
        end
        REG_PMC_ONE: begin
          if (reg_wdata[PMC1_WARN_ACK]) begin
            next_s.lowv_warning_flag = 1'b0;
          end
          next_s.lowv_warning_irq_enable = reg_wdata[PMC1_WARN_IE];
          next_s.lowv_reset_enable       = reg_wdata[PMC1_RESET_EN];
          next_s.lowv_stop_enable        = reg_wdata[PMC1_STOP_EN];
          next_s.lowv_detect_enable      = reg_wdata[PMC1_DETECT_EN];
        end
        REG_PMC_TWO: begin
          next_s.lowv_threshold_select = reg_wdata[PMC2_THRESH];
          next_s.stop2_select          = reg_wdata[PMC2_STOP2];
        end
        default: begin
          // Status, debug-force, identity and vector are read only.
        end
      endcase
    end

    // Hardware sets win over a clear in the same cycle.
    if (warn_set) begin
      next_s.lowv_warning_flag   = 1'b1;
      next_s.irq_status[EV_WARN] = 1'b1;
    end
    if (deny_set) begin
      next_s.irq_status[EV_STOP2_DENY] = 1'b1;
    end

    // Reset sequencer.
    case (s.rst_state)
      RST_POR_HOLD: begin
        // Stay in reset until the supply is above the low threshold,
        // then record a power-on plus low-voltage reset.
        if (supply_ok) begin
          next_s.rst_state = RST_RUN;
          next_s.reset_status_reg = BYTE_ZERO;
          next_s.reset_status_reg[RS_POR]  = 1'b1;
          next_s.reset_status_reg[RS_LOWV] = 1'b1;
        end
      end
      RST_RUN: begin
        // Any cause enters reset and records itself.
        if (any_cause) begin
          next_s.rst_state = RST_HOLD;
          // The power-on bit is left alone by a low-voltage reset.
          next_s.reset_status_reg[RS_POR]  = cause_lowv
                                             & s.reset_status_reg[RS_POR];
          next_s.reset_status_reg[RS_PIN]  = pin_active;
          next_s.reset_status_reg[RS_WDOG] = cause_wdog;
          next_s.reset_status_reg[RS_ILOP] = illegal_opcode;
          next_s.reset_status_reg[RS_ILAD] = illegal_address;
          next_s.reset_status_reg[RS_LOWV] = cause_lowv;
          if (cause_lowv) begin
            next_s.irq_status[EV_LOWV_TRIP] = 1'b1;
          end
          // Control bits other than the event mask return to their reset values in a reset.
          next_s.lowv_warning_flag       = 1'b0;
          next_s.lowv_warning_irq_enable = 1'b0;
          next_s.lowv_reset_enable       = RESET_EN_RST;
          next_s.lowv_stop_enable        = 1'b0;
          next_s.lowv_detect_enable      = DETECT_EN_RST;
          next_s.lowv_threshold_select   = 1'b0;
          next_s.stop2_select            = 1'b0;
          next_s.watchdog_reset_enable   = WDOG_EN_RST;
          next_s.sopt_written            = 1'b0;
        end
      end
      RST_HOLD: begin
        // Pin and low-voltage causes are levels: reset lasts until the pin is
        // released and the supply is back above the threshold.
        if (!hold_cause) begin
          next_s.rst_state = RST_RUN;
        end
      end
      default: begin
        next_s.rst_state = RST_POR_HOLD;
      end
    endcase
    next_s.sys_reset = (next_s.rst_state != RST_RUN);

    // Stop depth: the deepest stop is refused while detection must stay
    // powered, falling back to the lighter mode.
    if (!stop_req || next_s.sys_reset) begin
      next_s.stop_mode = STOP_NONE;
    end else if (s.stop_mode != STOP_NONE) begin
      next_s.stop_mode = s.stop_mode;
    end else if (s.stop2_select && !both_en) begin
      next_s.stop_mode = STOP_2;
    end else begin
      next_s.stop_mode = STOP_3;
    end

    // Detection powered by its enable, and in stop only with the
    // stop-enable also set.
    next_s.lowv_active = next_s.lowv_detect_enable
                         & ((next_s.stop_mode == STOP_NONE)
                            | next_s.lowv_stop_enable);
    // Threshold choice goes straight to the comparator.
    next_s.lowv_threshold_select = next_s.lowv_threshold_select;

    // Vector answer refreshed every enabled cycle.
    next_s.vec_num     = vp.num;
    next_s.cpu_irq     = vp.valid;
    // Pair of bytes per vector, high byte at the lower address, vector
    // zero at the very top.
    next_s.vec_addr_hi = VEC_TOP_ADDR - {10'h000, vp.num, 1'b0};

    // Event interrupt follows the masked sticky bits.
    next_s.irq = |(next_s.irq_status & next_s.irq_mask);

    // Read data stands in the cycle after the strobe only.
    next_s.rdata = BYTE_ZERO;
    if (reg_rd) begin
      case (reg_addr)
        REG_IRQ_STATUS:   next_s.rdata = {5'h00, s.irq_status};
        REG_RESET_STATUS: next_s.rdata = s.reset_status_reg;
        REG_DEBUG_FORCE:  next_s.rdata = BYTE_ZERO;
        REG_SYS_OPT_ONE:  next_s.rdata = sopt_rd;
        REG_IRQ_MASK:     next_s.rdata = {5'h00, s.irq_mask};
        REG_DEVICE_ID:    next_s.rdata = DEVICE_ID_VAL;
        REG_PMC_ONE:      next_s.rdata = pmc_one_rd;
        REG_PMC_TWO:      next_s.rdata = pmc_two_rd;
        REG_VECTOR:       next_s.rdata = {3'h0, s.vec_num};
        default:          next_s.rdata = BYTE_ZERO;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // State register.

  // Reset puts the block in the power-on hold with defaults; a low clock
  // enable freezes everything, including the read answer.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s                         <= '0;
      s.rst_state               <= RST_POR_HOLD;
      s.sys_reset               <= 1'b1;
      s.lowv_reset_enable       <= RESET_EN_RST;
      s.lowv_detect_enable      <= DETECT_EN_RST;
      s.watchdog_reset_enable   <= WDOG_EN_RST;
      s.lowv_active             <= DETECT_EN_RST;
      s.stop_mode               <= STOP_NONE;
      s.vec_addr_hi             <= VEC_TOP_ADDR;
      s.cpu_irq                 <= 1'b1;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state word.

  assign reg_rdata             = s.rdata;
  assign sys_reset             = s.sys_reset;
  assign cpu_irq_req           = s.cpu_irq;
  assign vec_num               = s.vec_num;
  assign vec_addr_hi           = s.vec_addr_hi;
  assign lowv_active           = s.lowv_active;
  assign lowv_threshold_select = s.lowv_threshold_select;
  assign stop_mode             = s.stop_mode;
  assign irq                   = s.irq;

endmodule : reset_vector_and_lvd_ctrl
`default_nettype wire

// File: tb/rv_props.sv
/* Checker for the vector and reset block, bound to its top module.
   Assumes one clock domain and the synchronous active-low reset. */
`timescale 1ns/100ps
`default_nettype none
module rv_props
  import rv_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        reset_pin_n,
  input wire logic        illegal_opcode,
  input wire logic        illegal_address,
  input wire logic        lowv_supply_ok,
  input wire logic        swi_req,
  input wire logic        stop_req,
  input wire logic        sys_reset,
  input wire logic        cpu_irq_req,
  input wire logic        lowv_active,
  input wire logic [4:0]  vec_num,
  input wire logic [15:0] vec_addr_hi,
  input wire logic [1:0]  stop_mode
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // The pin passes two synchroniser stages before the sequencer sees it.
  sequence s_pin_low; !reset_pin_n [*2]; endsequence
  // Vector n sits two bytes per step below the top pair.
  property p_addr; vec_addr_hi == {10'h3FF, ~vec_num, 1'b0}; endproperty
  a_addr: assert property (p_addr)
    else $error("bad vector address");
  property p_pin; s_pin_low |-> ##[1:4] sys_reset; endproperty
  a_pin: assert property (p_pin) else $error("pin reset missed");
  property p_ill;
    (illegal_opcode || illegal_address) && !sys_reset |=> sys_reset;
  endproperty
  a_ill: assert property (p_ill)
    else $error("illegal access reset missed");
  property p_hold;
    (sys_reset && !lowv_supply_ok) [*3] |=> sys_reset;
  endproperty
  a_hold: assert property (p_hold)
    else $error("reset left at low supply");
  property p_stop; $rose(stop_req) && !sys_reset |=> stop_mode != STOP_NONE;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop request ignored");
  property p_deep; stop_mode == STOP_2 |-> !lowv_active; endproperty
  a_deep: assert property (p_deep)
    else $error("detector on in stop2");
  property p_slot; cpu_irq_req |-> VEC_ASSIGNED[vec_num]; endproperty
  a_slot: assert property (p_slot)
    else $error("unassigned slot won");
  property p_prio; swi_req && !sys_reset |=> vec_num == VEC_SWI; endproperty
  a_prio: assert property (p_prio)
    else $error("wrong vector won");
endmodule : rv_props
bind reset_vector_and_lvd_ctrl rv_props props_u (.*);
`default_nettype wire

// File: tb/cpu_core_model.sv
/* Core model: raises the software interrupt on command and fetches the
   software interrupt vector once it is shown. Assumes the block's ref_clk and rst_n. */
`timescale 1ns/100ps
`default_nettype none
module cpu_core_model (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        swi_go,
  input  wire logic        cpu_irq_req,
  input  wire logic [15:0] vec_addr_hi,
  output var  logic        swi_req,
  output var  logic [15:0] fetch_addr
);
  // The request stays up until its own vector is fetched, as a core does.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      swi_req    <= 1'b0;
      fetch_addr <= 16'h0000;
    end else if (swi_go) begin
      swi_req <= 1'b1;
    end else if (swi_req && cpu_irq_req && vec_addr_hi == 16'hFFFC) begin
      swi_req    <= 1'b0;
      fetch_addr <= vec_addr_hi;
    end
  end
endmodule : cpu_core_model
`default_nettype wire

// File: tb/testbench.sv
/* Testbench: register tasks, then vectors, warning, stop and resets.
   Assumes the package, the block and the core model compile first. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import rv_pkg::*;
  logic ref_clk = 0, rst_n = 0, clk_en = 1, reg_wr = 0, reg_rd = 0;
  logic swi_go = 0, lowv_supply_ok = 1, lowv_warn_level = 0, stop_req = 0;
  logic reset_pin_n = 1, watchdog_timeout = 0, illegal_opcode = 0;
  logic illegal_address = 0, sys_reset, cpu_irq_req, lowv_active, irq;
  logic lowv_threshold_select, swi_req;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
  logic [31:0] periph_flag = 0, periph_enable = 0;
  logic [4:0] vec_num;
  logic [15:0] vec_addr_hi, fetch_addr;
  logic [1:0] stop_mode;
  logic [7:0] cause_rs [4] = '{8'h10, 8'h08, 8'h20, 8'h40};
  int error_cnt = 0, checks_done = 0;
  reset_vector_and_lvd_ctrl dut_u (.*);
  cpu_core_model core_u (.*);
  always #50 ref_clk = ~ref_clk;
  task chk(input string n, input logic [15:0] e, s);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task wr(input logic [7:0] a, d);
    @(posedge ref_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge ref_clk);
    reg_wr <= 0;
  endtask : wr
  task rd(input logic [7:0] a, e);
    @(posedge ref_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge ref_clk);
    reg_rd <= 0;
    #1 chk("reg_rdata", e, reg_rdata);
  endtask : rd
  // Bounded wait for the sequencer to let the system run again.
  task rel;
    for (int i = 0; i < 40 && sys_reset !== 1'b0; i++) cyc(1);
    chk("sys_reset", 0, sys_reset);
  endtask : rel
  task complete_run;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run
  initial begin
    #1_000_000;
    error_cnt++;
    complete_run();
  end
  initial begin
    cyc(15);
    @(posedge ref_clk) rst_n <= 1;
    rel();
    rd(REG_RESET_STATUS, 8'h82);
    rd(REG_PMC_ONE, 8'h14);
    rd(REG_DEVICE_ID, DEVICE_ID_VAL);
    rd(8'h20, 8'h00);
    @(posedge ref_clk) swi_go <= 1;
    @(posedge ref_clk) swi_go <= 0;
    cyc(4);
    chk("fetch_addr", 16'hFFFC, fetch_addr);
    @(posedge ref_clk) {periph_flag, periph_enable} <= {32'h64, 32'h44};
    rd(REG_VECTOR, 8'h06);
    @(posedge ref_clk) {periph_flag, periph_enable} <= 0;
    wr(REG_IRQ_MASK, 8'h01);
    wr(REG_PMC_ONE, 8'h34);
    @(posedge ref_clk) lowv_warn_level <= 1;
    cyc(5);
    rd(REG_VECTOR, 8'h03);
    chk("irq", 1, irq);
    @(posedge ref_clk) lowv_warn_level <= 0;
    rd(REG_PMC_ONE, 8'hB4);
    wr(REG_PMC_ONE, 8'h54);
    wr(REG_IRQ_STATUS, 8'h01);
    cyc(2);
    chk("irq", 0, irq);
    wr(REG_PMC_TWO, 8'h01);
    @(posedge ref_clk) stop_req <= 1;
    cyc(2);
    chk("stop_mode", STOP_2, stop_mode);
    chk("lowv_active", 0, lowv_active);
    @(posedge ref_clk) stop_req <= 0;
    wr(REG_PMC_ONE, 8'h1C);
    @(posedge ref_clk) stop_req <= 1;
    cyc(2);
    chk("stop_mode", STOP_3, stop_mode);
    chk("lowv_active", 1, lowv_active);
    @(posedge ref_clk) stop_req <= 0;
    rd(REG_IRQ_STATUS, 8'h04);
    wr(REG_PMC_TWO, 8'h20);
    cyc(2);
    chk("threshold", 1, lowv_threshold_select);
    @(posedge ref_clk) lowv_supply_ok <= 0;
    cyc(10);
    chk("sys_reset", 1, sys_reset);
    @(posedge ref_clk) lowv_supply_ok <= 1;
    rel();
    rd(REG_RESET_STATUS, 8'h82);
    for (int k = 0; k < 4; k++) begin
      @(posedge ref_clk);
      case (k)
        0: illegal_opcode <= 1;
        1: illegal_address <= 1;
        2: watchdog_timeout <= 1;
        default: reset_pin_n <= 0;
      endcase
      @(posedge ref_clk);
      {illegal_opcode, illegal_address, watchdog_timeout} <= 0;
      cyc(4);
      @(posedge ref_clk) reset_pin_n <= 1;
      rel();
      rd(REG_RESET_STATUS, cause_rs[k]);
    end
    wr(REG_SYS_OPT_ONE, 8'h00);
    wr(REG_SYS_OPT_ONE, 8'h80);
    rd(REG_SYS_OPT_ONE, 8'h00);
    @(posedge ref_clk) watchdog_timeout <= 1;
    @(posedge ref_clk) watchdog_timeout <= 0;
    cyc(3);
    chk("sys_reset", 0, sys_reset);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
